// *** inc/uel_pkg.sv ***
// Constants of the equalizer and link control bank
package uel_pkg;
    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DFP_EQ_OFFSET = 8'h20;
    localparam logic [7:0] UFP_EQ_OFFSET = 8'h21;
    localparam logic [7:0] MISC_OFFSET = 8'h22;
    localparam logic [7:0] DFP_EQ_RESET = 8'h00;
    localparam logic [7:0] UFP_EQ_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET = 8'h44;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SECOND_LVL_LSB = 4;
    localparam int FIRST_LVL_LSB = 0;
    localparam int UPSTREAM_LVL_LSB = 0;
    localparam int TERM_OFF_BIT = 7;
    localparam int LFPS_LEVEL_BIT = 6;
    localparam int EXIT_DEBOUNCE_BIT = 5;
    localparam int LP_DETECT_DIS_BIT = 4;
    localparam int INTERVAL_LSB = 2;
    localparam int SKIP_DETECT_BIT = 1;
    localparam int COMPLIANCE_DIS_BIT = 0;

    // ------------------------------------------------------------
    // Serial target address (value is arbitrary)
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h2a;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 10000;
    localparam int DEBOUNCE_US = 200;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam int INTERVAL0_CYC = 4 * CLK_KHZ;
    localparam int INTERVAL1_CYC = 6 * CLK_KHZ;
    localparam int INTERVAL2_CYC = 36 * CLK_KHZ;
    localparam int INTERVAL3_CYC = 84 * CLK_KHZ;

    // ------------------------------------------------------------
    // Serial port states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SP_IDLE = 4'b0000,
        SP_ADDR = 4'b0001,
        SP_ADDR_ACK = 4'b0010,
        SP_PTR = 4'b0011,
        SP_PTR_ACK = 4'b0100,
        SP_WDATA = 4'b0101,
        SP_WDATA_ACK = 4'b0110,
        SP_RDATA = 4'b0111,
        SP_RDATA_ACK = 4'b1000
    } uel_sp_state_t;
endpackage : uel_pkg

// *** hdl/uel_eq_link_ctrl.sv ***
// Equalizer and link control bank with serial target
//
// Notes on behaviour
// - Upper downstream nibble sets second receiver level
// - Lower downstream nibble sets first receiver level
// - Without override, downstream fields read sampled straps
// - With override, written downstream levels take effect
// - Adaptive mode x0 short channel uses fields
// - Upstream lower nibble sets level, upper reads zero
// - Upstream level follows straps unless override
// - Bit 7 turns termination off at detect start
// - Bit 6 clear forces level zero during LFPS
// - Bit 5 debounces LFPS 200 us before exit
// - Bit 4 blocks receiver detection in U2/U3
// - Bits 3-2 pick detect interval, 4/6/36/84 ms
// - Bit 1 skips detect after polled warm reset
// - Bit 0 disables compliance mode detection
// - Adaptive mode x0 long channel uses long levels
`timescale 1ns/1ns
module uel_eq_link_ctrl
    import uel_pkg::*;
#(
    parameter int INTERVAL0_CYCLES = INTERVAL0_CYC,
    parameter int INTERVAL1_CYCLES = INTERVAL1_CYC,
    parameter int INTERVAL2_CYCLES = INTERVAL2_CYC,
    parameter int INTERVAL3_CYCLES = INTERVAL3_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial management port
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Straps and equalizer mode controls
    input wire logic [1:0] downstreamLevelStraps,
    input wire logic [1:0] upstreamLevelStraps,
    input wire logic softwareLevelOverride,
    input wire logic adaptiveEqualizerEnable,
    input wire logic [1:0] adaptiveEqualizerMode,
    input wire logic longChannelDetected,
    input wire logic [3:0] firstRxLongChannelLevel,
    input wire logic [3:0] secondRxLongChannelLevel,
    // Link state inputs
    input wire logic receivingLfps,
    input wire logic inLowPower,
    input wire logic detectActive,
    input wire logic detectStartAfterWarmReset,
    input wire logic inactiveEntry,
    input wire logic detectDone,
    input wire logic inWarmReset,
    input wire logic partnerPolling,
    // Receiver levels
    output logic [3:0] firstDfpRxLevel,
    output logic [3:0] secondDfpRxLevel,
    output logic [3:0] upstreamRxLevel,
    // Link state controls
    output logic terminationOff,
    output logic lowPowerExit,
    output logic rxDetectStrobe,
    output logic skipDetectAfterWarmReset,
    output logic complianceDetectEnable
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] dfpEq_q;
    logic [3:0] ufpEq_q;
    logic [7:0] misc_q;
    logic [1:0] dnStrap_q;
    logic [1:0] upStrap_q;
    logic strapDone_q;

    // Strap capture after reset release
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dnStrap_q <= 2'h0;
            upStrap_q <= 2'h0;
            strapDone_q <= 1'b0;
        end else if (!strapDone_q) begin
            dnStrap_q <= downstreamLevelStraps;
            upStrap_q <= upstreamLevelStraps;
            strapDone_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Serial management target
    // ------------------------------------------------------------
    uel_sp_state_t state_q;
    logic sclPrev_q;
    logic sdaPrev_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic readMode_q;
    logic sdaOe_q;
    logic sdaOut_q;
    logic gotBit_q;

    wire sclRise = scl && !sclPrev_q;
    wire sclFall = !scl && sclPrev_q;
    wire startCond = scl && sclPrev_q && sdaPrev_q && !sdaIn;
    wire stopCond = scl && sclPrev_q && !sdaPrev_q && sdaIn;
    wire byteFull = (bitCnt_q == 3'h0) && gotBit_q;
    wire addrMatch = (shift_q[7:1] == TARGET_ADDR);
    wire regWrite = sclFall && (state_q == SP_WDATA) && byteFull;

    // Without override the level fields read the straps
    wire [3:0] dnStrapLvl = {2'h0, dnStrap_q};
    wire [3:0] upStrapLvl = {2'h0, upStrap_q};
    wire [7:0] dfpRead = softwareLevelOverride ? dfpEq_q : {dnStrapLvl, dnStrapLvl};
    wire [7:0] ufpRead = {4'h0, softwareLevelOverride ? ufpEq_q : upStrapLvl};
    wire [7:0] readData = (ptr_q == DFP_EQ_OFFSET) ? dfpRead :
                          (ptr_q == UFP_EQ_OFFSET) ? ufpRead :
                          (ptr_q == MISC_OFFSET) ? misc_q : 8'h00;

    // Line sampling; no byte counts as full before its first bit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            gotBit_q <= 1'b0;
        end else begin
            sclPrev_q <= scl;
            sdaPrev_q <= sdaIn;
            gotBit_q <= !startCond && (gotBit_q || sclRise);
        end
    end

    // Target: bits sampled on SCL rise, driven on fall
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SP_IDLE;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            readMode_q <= 1'b0;
            sdaOe_q <= 1'b0;
        end else if (startCond) begin
            state_q <= SP_ADDR;
            bitCnt_q <= 3'h0;
            sdaOe_q <= 1'b0;
        end else if (stopCond) begin
            state_q <= SP_IDLE;
            sdaOe_q <= 1'b0;
        end else if (sclRise) begin
            unique case (state_q)
                SP_ADDR, SP_PTR, SP_WDATA: begin
                    shift_q <= {shift_q[6:0], sdaIn};
                    bitCnt_q <= bitCnt_q + 3'h1;
                end
                SP_RDATA: begin
                    shift_q <= {shift_q[6:0], 1'b0};
                    bitCnt_q <= bitCnt_q + 3'h1;
                end
                SP_RDATA_ACK: begin
                    readMode_q <= !sdaIn; // Ack continues
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            unique case (state_q)
                SP_ADDR: begin
                    if (byteFull && addrMatch) begin
                        state_q <= SP_ADDR_ACK;
                        readMode_q <= shift_q[0];
                        sdaOe_q <= 1'b1;
                    end else if (byteFull) begin
                        state_q <= SP_IDLE;
                    end
                end
                SP_ADDR_ACK: begin
                    if (readMode_q) begin
                        state_q <= SP_RDATA;
                        shift_q <= readData;
                        sdaOe_q <= !readData[7];
                    end else begin
                        state_q <= SP_PTR;
                        sdaOe_q <= 1'b0;
                    end
                end
                SP_PTR: begin
                    if (byteFull) begin
                        state_q <= SP_PTR_ACK;
                        ptr_q <= shift_q;
                        sdaOe_q <= 1'b1;
                    end
                end
                SP_WDATA: begin
                    if (byteFull) begin
                        state_q <= SP_WDATA_ACK;
                        sdaOe_q <= 1'b1;
                    end
                end
                SP_PTR_ACK, SP_WDATA_ACK: begin
                    if (state_q == SP_WDATA_ACK) begin
                        ptr_q <= ptr_q + 8'h01;
                    end
                    state_q <= SP_WDATA;
                    sdaOe_q <= 1'b0;
                end
                SP_RDATA: begin
                    if (byteFull) begin
                        state_q <= SP_RDATA_ACK;
                        sdaOe_q <= 1'b0;
                    end else begin
                        sdaOe_q <= !shift_q[7];
                    end
                end
                SP_RDATA_ACK: begin
                    if (readMode_q) begin
                        state_q <= SP_RDATA;
                        ptr_q <= ptr_q + 8'h01;
                        shift_q <= (ptr_q == DFP_EQ_OFFSET) ? ufpRead :
                                   (ptr_q == UFP_EQ_OFFSET) ? misc_q : 8'h00;
                        sdaOe_q <= (ptr_q == DFP_EQ_OFFSET) ? !ufpRead[7] :
                                   (ptr_q == UFP_EQ_OFFSET) ? !misc_q[7] : 1'b1;
                    end else begin
                        state_q <= SP_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Open-drain data line only ever pulls low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sdaOut_q <= 1'b0;
        end else begin
            sdaOut_q <= 1'b0;
        end
    end

    assign sdaOe = sdaOe_q;
    assign sdaOut = sdaOut_q;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    wire dfpWrite = regWrite && (ptr_q == DFP_EQ_OFFSET) && softwareLevelOverride;
    wire ufpWrite = regWrite && (ptr_q == UFP_EQ_OFFSET) && softwareLevelOverride;
    wire miscWrite = regWrite && (ptr_q == MISC_OFFSET);

    // Level fields accept writes only under override
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dfpEq_q <= DFP_EQ_RESET;
            ufpEq_q <= UFP_EQ_RESET[3:0];
            misc_q <= MISC_RESET;
        end else begin
            if (dfpWrite) dfpEq_q <= shift_q;
            if (ufpWrite) ufpEq_q <= shift_q[3:0];
            if (miscWrite) misc_q <= shift_q;
        end
    end

    // ------------------------------------------------------------
    // Receiver level selection
    // ------------------------------------------------------------
    wire fastModeActive = adaptiveEqualizerEnable && !adaptiveEqualizerMode[0];
    wire useLong = fastModeActive && longChannelDetected;
    wire lfpsZero = receivingLfps && !misc_q[LFPS_LEVEL_BIT];
    wire [3:0] firstShort = dfpRead[FIRST_LVL_LSB +: 4];
    wire [3:0] secondShort = dfpRead[SECOND_LVL_LSB +: 4];
    wire [3:0] firstNext = lfpsZero ? 4'h0 : (useLong ? firstRxLongChannelLevel : firstShort);
    wire [3:0] secondNext = lfpsZero ? 4'h0 : (useLong ? secondRxLongChannelLevel : secondShort);
    wire [3:0] upstreamNext = lfpsZero ? 4'h0 : ufpRead[UPSTREAM_LVL_LSB +: 4];

    // Registered levels to the receivers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            firstDfpRxLevel <= 4'h0;
            secondDfpRxLevel <= 4'h0;
            upstreamRxLevel <= 4'h0;
        end else begin
            firstDfpRxLevel <= firstNext;
            secondDfpRxLevel <= secondNext;
            upstreamRxLevel <= upstreamNext;
        end
    end

    // ------------------------------------------------------------
    // Link state controls
    // ------------------------------------------------------------
    logic [11:0] debCnt_q;
    logic exitDone_q;
    logic [19:0] intCnt_q;
    logic pollSeen_q;

    wire lfpsWake = receivingLfps && inLowPower;
    wire debounceOn = misc_q[EXIT_DEBOUNCE_BIT];
    wire debounceMet = (debCnt_q == 12'(DEBOUNCE_CYC - 1));
    wire exitFire = lfpsWake && !exitDone_q && (!debounceOn || debounceMet);
    wire [1:0] intSel = misc_q[INTERVAL_LSB +: 2];
    wire [19:0] intLimit = (intSel == 2'h0) ? 20'(INTERVAL0_CYCLES - 1) :
                           (intSel == 2'h1) ? 20'(INTERVAL1_CYCLES - 1) :
                           (intSel == 2'h2) ? 20'(INTERVAL2_CYCLES - 1) : 20'(INTERVAL3_CYCLES - 1);
    wire intEnd = detectActive && (intCnt_q >= intLimit);
    wire detectBlocked = inLowPower && misc_q[LP_DETECT_DIS_BIT];
    wire termEvent = misc_q[TERM_OFF_BIT] && (detectStartAfterWarmReset || inactiveEntry);

    // LFPS debounce before low power exit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            debCnt_q <= 12'h000;
            exitDone_q <= 1'b0;
            lowPowerExit <= 1'b0;
        end else begin
            debCnt_q <= (lfpsWake && !debounceMet) ? debCnt_q + 12'h001 : (lfpsWake ? debCnt_q : 12'h000);
            exitDone_q <= lfpsWake && (exitDone_q || exitFire);
            lowPowerExit <= exitFire;
        end
    end

    // Receiver detection interval timer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            intCnt_q <= 20'h00000;
            rxDetectStrobe <= 1'b0;
        end else begin
            intCnt_q <= (!detectActive || intEnd) ? 20'h00000 : intCnt_q + 20'h00001;
            rxDetectStrobe <= intEnd && !detectBlocked;
        end
    end

    // Termination, polling and compliance; set wins
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            terminationOff <= 1'b0;
            pollSeen_q <= 1'b0;
            skipDetectAfterWarmReset <= 1'b0;
            complianceDetectEnable <= 1'b1;
        end else begin
            terminationOff <= termEvent || (terminationOff && !detectDone);
            pollSeen_q <= (inWarmReset && partnerPolling) || (pollSeen_q && !detectDone);
            skipDetectAfterWarmReset <= misc_q[SKIP_DETECT_BIT] && pollSeen_q;
            complianceDetectEnable <= !misc_q[COMPLIANCE_DIS_BIT];
        end
    end
endmodule : uel_eq_link_ctrl

// *** bench/uel_eq_link_monitor.sv ***
// Port checks for the equalizer and link control bank
`timescale 1ns/1ns
module uel_eq_link_monitor #(
    parameter int INTERVAL0_CYCLES = 40
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Level controls
    input wire logic softwareLevelOverride,
    input wire logic adaptiveEqualizerEnable,
    input wire logic [1:0] adaptiveEqualizerMode,
    input wire logic longChannelDetected,
    input wire logic [3:0] firstRxLongChannelLevel,
    input wire logic [3:0] secondRxLongChannelLevel,
    // Link state inputs
    input wire logic receivingLfps,
    input wire logic inLowPower,
    input wire logic detectActive,
    input wire logic detectStartAfterWarmReset,
    input wire logic inactiveEntry,
    input wire logic detectDone,
    input wire logic inWarmReset,
    input wire logic partnerPolling,
    // Outputs watched
    input wire logic [3:0] firstDfpRxLevel,
    input wire logic [3:0] secondDfpRxLevel,
    input wire logic [3:0] upstreamRxLevel,
    input wire logic terminationOff,
    input wire logic lowPowerExit,
    input wire logic rxDetectStrobe,
    input wire logic skipDetectAfterWarmReset
);
    int gapQ;
    logic seenQ;
    wire longPath = adaptiveEqualizerEnable && !adaptiveEqualizerMode[0] && longChannelDetected;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Cycles since last strobe; polling flag copy
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gapQ <= 0;
            seenQ <= 1'b0;
        end else begin
            gapQ <= (!detectActive || rxDetectStrobe) ? 0 : gapQ + 1;
            seenQ <= (inWarmReset && partnerPolling) || (seenQ && !detectDone);
        end
    end
    long_level_a: assert property (longPath && !receivingLfps |=> firstDfpRxLevel == $past(firstRxLongChannelLevel)
        && secondDfpRxLevel == $past(secondRxLongChannelLevel)) else $error("long level not applied");
    dfp_strap_a: assert property (!softwareLevelOverride && !longPath |=> firstDfpRxLevel[3:2] == 2'b00
        && secondDfpRxLevel[3:2] == 2'b00) else $error("dfp level not strapped");
    ufp_strap_a: assert property (!softwareLevelOverride |=> upstreamRxLevel[3:2] == 2'b00)
        else $error("ufp level not strapped");
    strap_hold_a: assert property ((!softwareLevelOverride && !receivingLfps)[*3] |=> $stable(upstreamRxLevel))
        else $error("strap level moved");
    exit_cause_a: assert property (lowPowerExit |-> $past(receivingLfps && inLowPower))
        else $error("exit without lfps");
    exit_pulse_a: assert property (lowPowerExit |=> !lowPowerExit) else $error("exit pulse too long");
    strobe_gap_a: assert property (rxDetectStrobe |-> gapQ >= INTERVAL0_CYCLES - 1)
        else $error("detect strobe too early");
    strobe_act_a: assert property (rxDetectStrobe |-> $past(detectActive)) else $error("strobe while idle");
    term_set_a: assert property ($rose(terminationOff) |-> $past(detectStartAfterWarmReset || inactiveEntry))
        else $error("term off uncaused");
    term_clear_a: assert property ($fell(terminationOff) |-> $past(detectDone))
        else $error("term restored early");
    skip_cause_a: assert property (skipDetectAfterWarmReset |-> $past(seenQ)) else $error("skip without polling");
endmodule : uel_eq_link_monitor

bind uel_eq_link_ctrl uel_eq_link_monitor #(.INTERVAL0_CYCLES(INTERVAL0_CYCLES)) mon (.sys_clk(sys_clk), .nrst(nrst),
    .softwareLevelOverride(softwareLevelOverride), .adaptiveEqualizerEnable(adaptiveEqualizerEnable),
    .adaptiveEqualizerMode(adaptiveEqualizerMode), .longChannelDetected(longChannelDetected),
    .firstRxLongChannelLevel(firstRxLongChannelLevel), .secondRxLongChannelLevel(secondRxLongChannelLevel),
    .receivingLfps(receivingLfps), .inLowPower(inLowPower), .detectActive(detectActive),
    .detectStartAfterWarmReset(detectStartAfterWarmReset), .inactiveEntry(inactiveEntry), .detectDone(detectDone),
    .inWarmReset(inWarmReset), .partnerPolling(partnerPolling), .firstDfpRxLevel(firstDfpRxLevel),
    .secondDfpRxLevel(secondDfpRxLevel), .upstreamRxLevel(upstreamRxLevel), .terminationOff(terminationOff),
    .lowPowerExit(lowPowerExit), .rxDetectStrobe(rxDetectStrobe), .skipDetectAfterWarmReset(skipDetectAfterWarmReset));

// *** bench/uel_sp_model.sv ***
// Serial management controller model with an open-drain data line
`timescale 1ns/1ns
module uel_sp_model
    import uel_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Target pull-down
    input wire logic sdaOe,
    // Bus lines
    output logic scl,
    output logic sdaIn
);
    logic sdaLow = 1'b0;
    initial scl = 1'b1;
    // Pulled-up wire
    assign sdaIn = ~(sdaLow | sdaOe);
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick
    // One bit, sampled mid high phase
    task automatic bitx(input logic b, output logic v);
        sdaLow = ~b;
        tick(2);
        scl = 1'b1;
        tick(1);
        v = sdaIn;
        tick(1);
        scl = 1'b0;
    endtask : bitx
    // Eight bits MSB first, ninth released
    task automatic bytex(input logic [7:0] d, output logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], v[i]);
        bitx(1'b1, a);
    endtask : bytex
    task automatic start();
        sdaLow = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        sdaLow = 1'b1;
        tick(2);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        sdaLow = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sdaLow = 1'b0;
        tick(2);
    endtask : stop
    task automatic wrReg(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] v;
        start();
        bytex({TARGET_ADDR, 1'b0}, v);
        bytex(p, v);
        bytex(d, v);
        stop();
    endtask : wrReg
    task automatic rdReg(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] v;
        start();
        bytex({TARGET_ADDR, 1'b0}, v);
        bytex(p, v);
        start();
        bytex({TARGET_ADDR, 1'b1}, v);
        bytex(8'hff, d);
        stop();
    endtask : rdReg
endmodule : uel_sp_model

// *** bench/tb_usb_eq_and_link_misc_ctrl.sv ***
// Self-checking bench for the equalizer and link control bank
`timescale 1ns/1ns
module tb_usb_eq_and_link_misc_ctrl;
    import uel_pkg::*;
    localparam int IV [4] = '{40, 60, 360, 840};
    logic sys_clk, nrst, ovr, aeqEn, longDet, lfps, lowPwr, detAct, detStart, inact, detDone, warm, poll;
    logic [1:0] ds, us, aeqMode;
    logic [3:0] long1, long2, first, second, up;
    logic scl, sdaIn, sdaOut, sdaOe, termOff, lpExit, strobe, skip, compEn;
    logic [7:0] rdQ, mv, r;
    logic [7:0] obs [8];
    logic [10:0] q [$];
    logic [31:0] seed = 32'h1ab6;
    int errors = 0, cmp_count = 0, n;
    event smp;
    string nm [8] = '{"first", "second", "upstream", "readback", "termOff", "skip", "compEn", "timing"};
    uel_eq_link_ctrl #(.INTERVAL0_CYCLES(IV[0]), .INTERVAL1_CYCLES(IV[1]), .INTERVAL2_CYCLES(IV[2]),
        .INTERVAL3_CYCLES(IV[3])) uut (.sys_clk(sys_clk), .nrst(nrst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .downstreamLevelStraps(ds), .upstreamLevelStraps(us), .softwareLevelOverride(ovr),
        .adaptiveEqualizerEnable(aeqEn), .adaptiveEqualizerMode(aeqMode), .longChannelDetected(longDet),
        .firstRxLongChannelLevel(long1), .secondRxLongChannelLevel(long2), .receivingLfps(lfps),
        .inLowPower(lowPwr), .detectActive(detAct), .detectStartAfterWarmReset(detStart), .inactiveEntry(inact),
        .detectDone(detDone), .inWarmReset(warm), .partnerPolling(poll), .firstDfpRxLevel(first),
        .secondDfpRxLevel(second), .upstreamRxLevel(up), .terminationOff(termOff), .lowPowerExit(lpExit),
        .rxDetectStrobe(strobe), .skipDetectAfterWarmReset(skip), .complianceDetectEnable(compEn));
    uel_sp_model sp (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Observed values
    always_comb begin
        obs = '{{4'h0, first}, {4'h0, second}, {4'h0, up}, rdQ, {7'h0, termOff}, {7'h0, skip}, {7'h0, compEn}, mv};
    end
    // Oldest note against its output
    always @(smp) begin
        logic [10:0] it;
        it = q.pop_front();
        cmp_count++;
        if (obs[it[10:8]] !== it[7:0]) begin
            errors++;
            $display("wrong value %s exp %h got %h", nm[it[10:8]], it[7:0], obs[it[10:8]]);
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick
    task automatic note(input logic [2:0] s, input logic [7:0] e);
        q.push_back({s, e});
        ->smp;
        #1;
    endtask : note
    task automatic results();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // Bounded wait for a pulse
    task automatic waitp(input bit k, input int lim, input bit must);
        n = 0;
        while (((k ? strobe : lpExit) !== 1'b1) && n < lim) begin
            tick(1);
            n++;
        end
        if (must && n >= lim) begin
            errors++;
            results();
        end
    endtask : waitp
    initial begin
        {ovr, aeqEn, aeqMode, longDet, long1, long2, lfps, lowPwr, detAct, detStart, inact, detDone, warm, poll} = '0;
        nrst = 1'b0;
        mv = 8'h00;
        repeat (8) seed = lfsr(seed);
        {us, ds} = seed[3:0];
        r = seed[15:8];
        {long2, long1} = seed[23:16];
        tick(6);
        nrst = 1'b1;
        tick(3);
        note(0, {6'h0, ds});
        note(2, {6'h0, us});
        ds = ~ds;
        us = ~us;
        tick(3);
        note(1, {6'h0, ~ds});
        note(2, {6'h0, ~us});
        sp.rdReg(MISC_OFFSET, rdQ);
        note(3, MISC_RESET);
        sp.rdReg(UFP_EQ_OFFSET, rdQ);
        note(3, {6'h0, ~us});
        sp.rdReg(DFP_EQ_OFFSET, rdQ);
        note(3, {2'b00, ~ds, 2'b00, ~ds});
        sp.rdReg(8'h30, rdQ);
        note(3, 8'h00);
        sp.wrReg(DFP_EQ_OFFSET, r);
        tick(2);
        note(0, {6'h0, ~ds});
        ovr = 1'b1;
        sp.wrReg(DFP_EQ_OFFSET, r);
        tick(2);
        note(0, {4'h0, r[3:0]});
        note(1, {4'h0, r[7:4]});
        sp.wrReg(UFP_EQ_OFFSET, 8'hff);
        sp.rdReg(UFP_EQ_OFFSET, rdQ);
        note(3, 8'h0f);
        note(2, 8'h0f);
        lfps = 1'b1;
        tick(2);
        note(0, {4'h0, r[3:0]});
        sp.wrReg(MISC_OFFSET, 8'h01);
        note(6, 8'h00);
        note(0, 8'h00);
        note(1, 8'h00);
        lfps = 1'b0;
        {aeqEn, aeqMode, longDet} = 4'b1101;
        tick(2);
        note(0, {4'h0, long1});
        note(1, {4'h0, long2});
        longDet = 1'b0;
        tick(2);
        note(0, {4'h0, r[3:0]});
        {aeqMode, longDet} = 3'b011;
        tick(2);
        note(1, {4'h0, r[7:4]});
        aeqEn = 1'b0;
        {lfps, lowPwr} = 2'b11;
        waitp(1'b0, 10, 1'b1);
        mv = {7'h0, n == 1};
        note(7, 8'h01);
        {lfps, lowPwr} = 2'b00;
        sp.wrReg(MISC_OFFSET, 8'h20);
        note(6, 8'h01);
        {lfps, lowPwr} = 2'b11;
        waitp(1'b0, DEBOUNCE_CYC + 10, 1'b1);
        mv = {7'h0, n >= DEBOUNCE_CYC && n <= DEBOUNCE_CYC + 1};
        note(7, 8'h01);
        {lfps, lowPwr} = 2'b00;
        // Second gap is exact
        for (int c = 0; c < 4; c++) begin
            sp.wrReg(MISC_OFFSET, 8'(c << 2));
            detAct = 1'b1;
            waitp(1'b1, IV[c] + 5, 1'b1);
            tick(1);
            waitp(1'b1, IV[c] + 5, 1'b1);
            mv = {7'h0, n == IV[c] - 1};
            note(7, 8'h01);
            detAct = 1'b0;
        end
        sp.wrReg(MISC_OFFSET, 8'h10);
        {lowPwr, detAct} = 2'b11;
        waitp(1'b1, 100, 1'b0);
        mv = {7'h0, n >= 100};
        note(7, 8'h01);
        lowPwr = 1'b0;
        waitp(1'b1, 100, 1'b1);
        detAct = 1'b0;
        sp.wrReg(MISC_OFFSET, 8'h82);
        {warm, poll, detStart} = 3'b111;
        tick(1);
        {warm, poll, detStart} = 3'b000;
        tick(3);
        note(4, 8'h01);
        note(5, 8'h01);
        detDone = 1'b1;
        tick(1);
        detDone = 1'b0;
        tick(3);
        note(4, 8'h00);
        note(5, 8'h00);
        inact = 1'b1;
        tick(1);
        inact = 1'b0;
        tick(2);
        note(4, 8'h01);
        detDone = 1'b1;
        tick(1);
        detDone = 1'b0;
        sp.wrReg(MISC_OFFSET, 8'h00);
        {inact, warm, poll} = 3'b111;
        tick(1);
        {inact, warm, poll} = 3'b000;
        tick(3);
        note(4, 8'h00);
        note(5, 8'h00);
        results();
    end
endmodule : tb_usb_eq_and_link_misc_ctrl
